// ===== rtl/ptl_timer.sv
// period timer with postscaler and external reset source handling
// assumes software strobes are same-domain; ext_src comes from pins
`timescale 1ns/1ns
module ptl_timer #(
  parameter int unsigned NUM_SRC = 4,
  parameter int unsigned SEL_W   = 2
) (
  input  wire logic                       clk_sys,
  input  wire logic                       rst_n,
  input  wire logic                       count_wr,
  input  wire logic [ptl_pkg::CNT_W-1:0]  count_wdata,
  input  wire logic                       period_wr,
  input  wire logic [ptl_pkg::CNT_W-1:0]  period_wdata,
  input  wire logic                       ctrl_wr,
  input  wire logic                       ctrl_on,
  input  wire logic [ptl_pkg::PRE_W-1:0]  ctrl_prescale,
  input  wire logic [ptl_pkg::POST_W-1:0] ctrl_postscale,
  input  wire logic                       hlt_wr,
  input  wire logic [ptl_pkg::MODE_W-1:0] hlt_mode,
  input  wire logic                       rst_sel_wr,
  input  wire logic [SEL_W-1:0]           rst_sel_wdata,
  input  wire logic [NUM_SRC-1:0]         ext_src,
  input  wire logic                       debug_freeze,
  output logic [ptl_pkg::CNT_W-1:0]       timer_count,
  output logic [ptl_pkg::CNT_W-1:0]       period_value,
  output logic                            timer_on_bit,
  output logic [ptl_pkg::PRE_W-1:0]       prescale_select,
  output logic [ptl_pkg::POST_W-1:0]      postscale_select,
  output logic [ptl_pkg::MODE_W-1:0]      hw_limit_mode,
  output logic [SEL_W-1:0]                reset_source_select,
  output logic                            timer_tick,
  output logic                            period_match,
  output logic                            postscaled_pulse
);
  import ptl_pkg::*;

  logic [CNT_W-1:0]   count_ff, period_ff;
  logic               on_ff, stopped_ff, pulse_ff;
  logic [PRE_W-1:0]   pre_sel_ff;
  logic [POST_W-1:0]  post_sel_ff, post_cnt_ff;
  logic [MODE_W-1:0]  mode_ff;
  logic [SEL_W-1:0]   src_sel_ff;
  logic [NUM_SRC-1:0] src_s1_ff, src_s2_ff;
  logic               src_lvl_ff, src_prev_ff, frz_d_ff;
  logic               tick, clr_scalers, running, match;
  logic               ext_rise, ext_fall, ext_edge_evt, ext_lvl_rst, ext_evt;
  logic               gate_ok, src_now;
  ptl_major_t         major;
  ptl_opt_t           opt;

  assign major = ptl_major_t'(mode_ff[MODE_MAJ_HI:MODE_MAJ_LO]);
  assign opt   = ptl_opt_t'(mode_ff[MODE_OPT_HI:0]);

  // ----------------------------------------------------------------
  // external source: sync, select, freeze
  // ----------------------------------------------------------------
  // two-flop synchroniser per source pin
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      src_s1_ff <= '0;
      src_s2_ff <= '0;
    end else begin
      src_s1_ff <= ext_src;
      src_s2_ff <= src_s1_ff;
    end
  end

  assign src_now = src_s2_ff[src_sel_ff];

  // selected level, held frozen while debugging
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      src_lvl_ff  <= 1'b0;
      src_prev_ff <= 1'b0;
      frz_d_ff    <= 1'b0;
    end else begin
      frz_d_ff <= debug_freeze;
      if (!debug_freeze) begin
        src_lvl_ff <= src_now;
      end
      // leaving freeze reloads both, so a change made while frozen fires no edge
      if (frz_d_ff && !debug_freeze) begin
        src_prev_ff <= src_now;
      end else begin
        src_prev_ff <= src_lvl_ff;
      end
    end
  end

  // trigger decode from the chosen option
  always_comb begin
    ext_rise     = src_lvl_ff && !src_prev_ff;
    ext_fall     = !src_lvl_ff && src_prev_ff;
    ext_edge_evt = 1'b0;
    ext_lvl_rst  = 1'b0;
    gate_ok      = 1'b1;
    case (opt)
      PTL_OPT_GATEH: gate_ok = src_lvl_ff;
      PTL_OPT_GATEL: gate_ok = !src_lvl_ff;
      PTL_OPT_RISE:  ext_edge_evt = ext_rise;
      PTL_OPT_FALL:  ext_edge_evt = ext_fall;
      PTL_OPT_ANY:   ext_edge_evt = ext_rise || ext_fall;
      PTL_OPT_LVLH:  ext_lvl_rst = src_lvl_ff;
      PTL_OPT_LVLL:  ext_lvl_rst = !src_lvl_ff;
      default:       gate_ok = 1'b1;
    endcase
  end
  assign ext_evt = (ext_edge_evt || ext_lvl_rst) && on_ff;

  // ----------------------------------------------------------------
  // prescaler and run condition
  // ----------------------------------------------------------------
  assign clr_scalers = count_wr || ctrl_wr || ext_evt;
  assign running     = on_ff && !stopped_ff && gate_ok && !ext_lvl_rst
                       && (major != PTL_RSVD);

  ptl_prescaler #(.DIV_W(8)) u_pre (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .clr     (clr_scalers),
    .sel     (pre_sel_ff),
    .tick    (tick)
  );

  assign match = tick && running && (count_ff == period_ff);

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pre_sel_ff  <= PRE_RST;
      post_sel_ff <= POST_RST;
      mode_ff     <= MODE_RST;
      src_sel_ff  <= '0;
      period_ff   <= PER_RST;
    end else begin
      if (ctrl_wr) begin
        pre_sel_ff  <= ctrl_prescale;
        post_sel_ff <= ctrl_postscale;
      end
      if (hlt_wr) begin
        mode_ff <= hlt_mode;
      end
      if (rst_sel_wr) begin
        src_sel_ff <= rst_sel_wdata;
      end
      if (period_wr) begin
        period_ff <= period_wdata;
      end
    end
  end

  // on bit: software write beats the one-shot self clear
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      on_ff <= 1'b0;
    end else if (ctrl_wr) begin
      on_ff <= ctrl_on;
    end else if (match && major == PTL_ONESHOT) begin
      on_ff <= 1'b0;
    end
  end

  // monostable halt, released by an external event or restart
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      stopped_ff <= 1'b0;
    end else if (ext_evt || ctrl_wr) begin
      stopped_ff <= 1'b0;
    end else if (match && major == PTL_MONO) begin
      stopped_ff <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // count register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      count_ff <= CNT_RST;
    end else if (count_wr) begin
      count_ff <= count_wdata;
    end else if (ext_evt) begin
      count_ff <= '0;
    end else if (match) begin
      count_ff <= '0;
    end else if (tick && running) begin
      count_ff <= count_ff + CNT_W'(1);
    end
  end

  // ----------------------------------------------------------------
  // postscaler and output pulse
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      post_cnt_ff <= '0;
    end else if (clr_scalers) begin
      post_cnt_ff <= '0;
    end else if (match) begin
      if (post_cnt_ff == post_sel_ff) begin
        post_cnt_ff <= '0;
      end else begin
        post_cnt_ff <= post_cnt_ff + POST_W'(1);
      end
    end
  end

  // pulse lasts one tick period unless a count write, control write or external event clears it first
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pulse_ff <= 1'b0;
    end else if (clr_scalers) begin
      pulse_ff <= 1'b0;
    end else if (tick) begin
      pulse_ff <= match && (post_cnt_ff == post_sel_ff) && !clr_scalers;
    end
  end

  // exported signals for converter, shutdown and pwm users
  assign timer_count         = count_ff;
  assign period_value        = period_ff;
  assign postscaled_pulse    = pulse_ff;
  assign timer_tick          = tick;
  assign period_match        = match;
  assign timer_on_bit        = on_ff;
  assign prescale_select     = pre_sel_ff;
  assign postscale_select    = post_sel_ff;
  assign hw_limit_mode       = mode_ff;
  assign reset_source_select = src_sel_ff;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_match_wraps: assert property (@(posedge clk_sys) disable iff (!rst_n)
    match && !count_wr |=> count_ff == '0)
    else $error("count did not return to zero after match");
  a_count_steps: assert property (@(posedge clk_sys) disable iff (!rst_n)
    tick && running && !match && !count_wr && !ext_evt
    |=> count_ff == $past(count_ff) + CNT_W'(1))
    else $error("count did not advance on tick");
  a_idle_holds: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !tick && !count_wr && !ext_evt |=> $stable(count_ff))
    else $error("count moved without a tick");
  a_gate_stops: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !gate_ok && !count_wr && !ext_evt |=> $stable(count_ff))
    else $error("count moved while gate inactive");
  a_ext_clears: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ext_evt && !count_wr |=> count_ff == '0 && post_cnt_ff == '0)
    else $error("external event did not clear timer");
  a_ctrl_keeps: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ctrl_wr && !count_wr && !ext_evt && !(tick && running)
    |=> $stable(count_ff) && post_cnt_ff == '0)
    else $error("control write disturbed count or kept postscaler");
  a_pulse_width: assert property (@(posedge clk_sys) disable iff (!rst_n)
    pulse_ff && !tick && !clr_scalers |=> pulse_ff)
    else $error("postscaled pulse ended before next tick");
  a_pulse_ends: assert property (@(posedge clk_sys) disable iff (!rst_n)
    pulse_ff && tick && !match |=> !pulse_ff)
    else $error("postscaled pulse outlasted one tick");
  a_oneshot_off: assert property (@(posedge clk_sys) disable iff (!rst_n)
    match && major == PTL_ONESHOT && !ctrl_wr |=> !on_ff ##1 $stable(count_ff))
    else $error("one-shot kept running after match");
  a_mono_stays: assert property (@(posedge clk_sys) disable iff (!rst_n)
    match && major == PTL_MONO && !ctrl_wr |=> on_ff && (stopped_ff || ext_evt))
    else $error("monostable did not hold after match");
  a_freeze_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
    debug_freeze && $past(debug_freeze) |-> $stable(src_lvl_ff))
    else $error("trigger changed during debug freeze");
endmodule

// ===== inc/ptl_pkg.sv
// period timer with hardware limit: shared constants and types
// assumes a single 100 MHz system clock and active-low async reset
package ptl_pkg;

  // ----------------------------------------------------------------
  // widths and reset values
  // ----------------------------------------------------------------
  localparam int unsigned CNT_W   = 8;
  localparam int unsigned PRE_W   = 3;
  localparam int unsigned POST_W  = 5;
  localparam int unsigned MODE_W  = 5;
  localparam logic [7:0]  CNT_RST = 8'h00;
  localparam logic [7:0]  PER_RST = 8'hFF;
  localparam logic [4:0]  POST_RST = 5'h00;
  localparam logic [4:0]  MODE_RST = 5'h00;
  localparam logic [2:0]  PRE_RST  = 3'h0;

  // ----------------------------------------------------------------
  // mode field layout: [4:3] major mode, [2:0] option
  // ----------------------------------------------------------------
  localparam int unsigned MODE_MAJ_HI = 4;
  localparam int unsigned MODE_MAJ_LO = 3;
  localparam int unsigned MODE_OPT_HI = 2;

  typedef enum logic [1:0] {
    PTL_FREE = 2'h0,
    PTL_ONESHOT = 2'h1,
    PTL_MONO = 2'h2,
    PTL_RSVD = 2'h3
  } ptl_major_t;

  typedef enum logic [2:0] {
    PTL_OPT_SW    = 3'h0,  // software control only
    PTL_OPT_GATEH = 3'h1,  // counts while source high
    PTL_OPT_GATEL = 3'h2,  // counts while source low
    PTL_OPT_RISE  = 3'h3,  // reset on rising edge
    PTL_OPT_FALL  = 3'h4,  // reset on falling edge
    PTL_OPT_ANY   = 3'h5,  // reset on either edge
    PTL_OPT_LVLH  = 3'h6,  // held in reset while high
    PTL_OPT_LVLL  = 3'h7   // held in reset while low
  } ptl_opt_t;

  // far-side trigger spacing, in timer ticks
  localparam int unsigned EDGE_GAP_TICKS = 6;
  localparam int unsigned LVL_MIN_TICKS  = 3;

endpackage

// ===== rtl/ptl_prescaler.sv
// programmable prescaler: divides clk_sys by 2^sel into a tick pulse
// assumes clr is a same-domain one-cycle or level request
`timescale 1ns/1ns
module ptl_prescaler #(
  parameter int unsigned DIV_W = 8
) (
  input  wire logic                    clk_sys,
  input  wire logic                    rst_n,
  input  wire logic                    clr,
  input  wire logic [ptl_pkg::PRE_W-1:0] sel,
  output logic                         tick
);
  import ptl_pkg::*;

  logic [DIV_W-1:0] div_ff;
  logic [DIV_W-1:0] lim;

  // terminal count for the chosen ratio
  assign lim  = DIV_W'((1 << sel) - 1);
  assign tick = (div_ff == lim) && !clr;

  // ----------------------------------------------------------------
  // divider counter
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      div_ff <= '0;
    end else if (clr || tick) begin
      div_ff <= '0;
    end else begin
      div_ff <= div_ff + DIV_W'(1);
    end
  end
endmodule

// ===== test/ptl_src_model.sv
// far-side model: logic that drives the timer's external reset sources
// assumes the timer ticks every clk_sys cycle while this source is in use
`timescale 1ns/1ns
module ptl_src_model (
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic       want,
  output logic [3:0]      ext_src
);
  logic [3:0] gap_ff;
  logic       lvl_ff;
  logic [2:0] noise_ff;

  // follow the request, at most one change every seven cycles
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      gap_ff   <= 4'h0;
      lvl_ff   <= 1'b0;
      noise_ff <= 3'h0;
    end else begin
      noise_ff <= noise_ff + 3'h1; // unselected sources keep moving
      if (gap_ff != 4'h0) begin
        gap_ff <= gap_ff - 4'h1;
      end else if (want != lvl_ff) begin
        lvl_ff <= want;
        gap_ff <= 4'(ptl_pkg::EDGE_GAP_TICKS);
      end
    end
  end

  assign ext_src = {noise_ff, lvl_ff};
endmodule

// ===== test/period_timer_with_hw_limit_tb.sv
// self-checking bench for the period timer
// assumes inputs change on falling clk_sys edges, outputs sampled there too
`timescale 1ns/1ns
module period_timer_with_hw_limit_tb;
  import ptl_pkg::*;
  logic clk_sys = 1'b0, rst_n = 1'b0, want = 1'b0, debug_freeze = 1'b0;
  logic count_wr = 1'b0, period_wr = 1'b0, ctrl_wr = 1'b0, ctrl_on = 1'b0;
  logic hlt_wr = 1'b0, rst_sel_wr = 1'b0;
  logic [7:0] count_wdata = 8'h00, period_wdata = 8'h00, timer_count, period_value;
  logic [2:0] ctrl_prescale = 3'h0, prescale_select;
  logic [4:0] ctrl_postscale = 5'h00, hlt_mode = 5'h00, postscale_select, hw_limit_mode;
  logic [1:0] rst_sel_wdata = 2'h0, reset_source_select;
  logic [3:0] ext_src;
  logic timer_on_bit, period_match, postscaled_pulse, timer_tick;
  int error_cnt = 0, checked = 0;

  always #5 clk_sys = ~clk_sys;

  ptl_src_model u_src (.clk_sys(clk_sys), .rst_n(rst_n), .want(want), .ext_src(ext_src));

  ptl_timer dut (.clk_sys(clk_sys), .rst_n(rst_n), .count_wr(count_wr),
    .count_wdata(count_wdata), .period_wr(period_wr), .period_wdata(period_wdata),
    .ctrl_wr(ctrl_wr), .ctrl_on(ctrl_on), .ctrl_prescale(ctrl_prescale),
    .ctrl_postscale(ctrl_postscale), .hlt_wr(hlt_wr), .hlt_mode(hlt_mode),
    .rst_sel_wr(rst_sel_wr), .rst_sel_wdata(rst_sel_wdata), .ext_src(ext_src),
    .debug_freeze(debug_freeze), .timer_count(timer_count), .period_value(period_value),
    .timer_on_bit(timer_on_bit), .prescale_select(prescale_select),
    .postscale_select(postscale_select), .hw_limit_mode(hw_limit_mode),
    .reset_source_select(reset_source_select), .timer_tick(timer_tick),
    .period_match(period_match), .postscaled_pulse(postscaled_pulse));

  // compare and count
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("errors=%0d checks=%0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  // mode, period and count zero, then control write
  task automatic cfg(input logic [4:0] m, input logic [7:0] p, input logic [4:0] ps,
                     input logic [2:0] pre, input logic on);
    @(negedge clk_sys);
    hlt_mode = m; hlt_wr = 1'b1; period_wdata = p; period_wr = 1'b1;
    count_wdata = 8'h00; count_wr = 1'b1;
    @(negedge clk_sys);
    hlt_wr = 1'b0; period_wr = 1'b0; count_wr = 1'b0;
    ctrl_on = on; ctrl_postscale = ps; ctrl_prescale = pre; ctrl_wr = 1'b1;
    @(negedge clk_sys);
    ctrl_wr = 1'b0;
    chk(period_value, p);
    chk(hw_limit_mode, m);
    chk({prescale_select, postscale_select}, {pre, ps});
  endtask

  task automatic wait_match();
    int k;
    for (k = 0; k < 2000; k++) begin
      @(negedge clk_sys);
      if (period_match === 1'b1) return;
    end
    chk(8'h00, 8'h01);
  endtask

  // match spacing versus prescale, wrap to zero
  task automatic t_period();
    int n, pre, t;
    for (pre = 0; pre < 3; pre++) begin
      cfg(5'h00, 8'h02, 5'h00, 3'(pre), 1'b1);
      wait_match();
      chk(timer_count, 8'h02);
      n = 0;
      t = 0;
      do begin
        cyc(1);
        n++;
        if (timer_tick === 1'b1) t++;
      end while (period_match !== 1'b1 && n < 100);
      chk(8'(n), 8'(3 << pre));
      chk(8'(t), 8'h03);
    end
  endtask

  // three matches between postscaled pulses, the first one checked one cycle wide
  task automatic t_post();
    int k, n;
    cfg(5'h00, 8'h02, 5'h02, 3'h0, 1'b1);
    n = 0;
    for (k = 0; k < 100 && postscaled_pulse !== 1'b1; k++) cyc(1);
    cyc(1);
    chk(postscaled_pulse, 8'h00);
    for (k = 0; k < 100 && postscaled_pulse !== 1'b1; k++) begin
      cyc(1);
      if (period_match === 1'b1) n++;
    end
    chk(8'(n), 8'h03);
  endtask

  // count write clears prescaler, control write keeps count
  task automatic t_writes();
    cfg(5'h00, 8'hff, 5'h00, 3'h2, 1'b1);
    cyc(5);
    count_wdata = 8'h10; count_wr = 1'b1;
    cyc(1);
    count_wr = 1'b0;
    cyc(2);
    chk(timer_count, 8'h10);
    cyc(3);
    chk(timer_count, 8'h11);
    ctrl_on = 1'b0; ctrl_wr = 1'b1;
    cyc(1);
    ctrl_wr = 1'b0;
    cyc(3);
    chk(timer_on_bit, 8'h00);
    chk(timer_count, 8'h11);
  endtask

  // one-shot and monostable stop at the match
  task automatic t_stop(input logic [4:0] m, input logic on_exp);
    logic [7:0] c;
    cfg(5'h00, 8'h03, 5'h00, 3'h0, 1'b0);
    cfg(m, 8'h03, 5'h00, 3'h0, 1'b1);
    wait_match();
    cyc(1);
    chk(postscaled_pulse, 8'h01);
    cyc(1);
    chk(timer_on_bit, 8'(on_exp));
    c = timer_count;
    cyc(5);
    chk(timer_count, c);
  endtask

  // gate, level reset, edge restart and freeze through the source
  task automatic t_ext();
    logic [7:0] c;
    rst_sel_wdata = 2'h2; rst_sel_wr = 1'b1;
    cyc(1);
    rst_sel_wdata = 2'h0;
    cyc(1);
    rst_sel_wr = 1'b0;
    chk(reset_source_select, 8'h00);
    t_stop(5'h13, 1'b1);
    want = 1'b1;
    wait_match();
    want = 1'b0;
    cfg(5'h01, 8'hff, 5'h00, 3'h0, 1'b1);
    cyc(14);
    c = timer_count;
    cyc(4);
    chk(timer_count, c);
    want = 1'b1;
    cyc(14);
    chk(timer_count > c + 8'h08, 8'h01);
    debug_freeze = 1'b1;
    want = 1'b0;
    cyc(14);
    c = timer_count;
    cyc(2);
    chk(timer_count, c + 8'h02);
    debug_freeze = 1'b0;
    cfg(5'h06, 8'hff, 5'h00, 3'h0, 1'b1);
    want = 1'b1;
    cyc(14);
    chk(timer_count, 8'h00);
    want = 1'b0;
    cyc(14);
    chk(timer_count > 8'h04, 8'h01);
    cfg(5'h04, 8'hff, 5'h00, 3'h0, 1'b1);
    want = 1'b1;
    cyc(14);
    want = 1'b0;
    cyc(6);
    chk(timer_count < 8'h04, 8'h01);
  endtask

  initial begin
    cyc(10);
    rst_n = 1'b1;
    cyc(1);
    chk(timer_count, 8'h00);
    chk(period_value, 8'hff);
    chk(timer_on_bit, 8'h00);
    chk({prescale_select, hw_limit_mode}, 8'h00);
    chk({postscale_select, reset_source_select}, 8'h00);
    t_period();
    t_post();
    t_writes();
    t_stop(5'h08, 1'b0);
    t_ext();
    stop_test();
  end

  // hang guard
  initial begin
    #200000;
    error_cnt++;
    stop_test();
  end
endmodule
